// ---- inc/cigc_regs.svh ----
// register offsets, field positions and timing constants of the configuration pin controller
// Notes on behaviour
// - external start-up clock paces initialization when enabled
// - indicator undriven while restart low, config start
// - loaded indicator option drives indicator low
// - initialization done releases indicator, enters user mode
// - global output enable low tristates all user I/O pins
// - global clear low clears all device registers
// - disabled option makes pin ordinary user I/O
`ifndef CIGC_REGS_SVH
`define CIGC_REGS_SVH

`define CIGC_ADDR_W 8
`define CIGC_DATA_W 32
`define CIGC_SYNC_W 5

`define CIGC_REG_OPTIONS 8'h00
`define CIGC_REG_STATUS 8'h04
`define CIGC_REG_IRQ_STAT 8'h08
`define CIGC_REG_IRQ_MASK 8'h0C

`define CIGC_OPT_CLK 0
`define CIGC_OPT_INIT 1
`define CIGC_OPT_OE 2
`define CIGC_OPT_CLR 3

`define CIGC_EV_USER 0
`define CIGC_EV_RESTART 1
`define CIGC_EV_CLEAR 2
`define CIGC_EV_TRISTATE 3

`define CIGC_RESP_OKAY 2'h0
`define CIGC_RESP_SLVERR 2'h2

`define CIGC_CLK_PERIOD_NS 25
`define CIGC_INT_TICK_NS 200
`define CIGC_INT_TICK_CYC ((`CIGC_INT_TICK_NS + `CIGC_CLK_PERIOD_NS - 1) / `CIGC_CLK_PERIOD_NS)
`define CIGC_DIV_W 4
`define CIGC_DIV_LAST 4'(`CIGC_INT_TICK_CYC - 1)
`define CIGC_INIT_CNT_W 4
`define CIGC_INIT_LAST 4'h7

`endif

// ---- inc/cigc_pkg.sv ----
// types of the configuration pin controller
`include "cigc_regs.svh"
package cigc_pkg;

    typedef enum logic [2:0] {
        CIGC_S_HOLD = 3'b000,
        CIGC_S_CFG = 3'b001,
        CIGC_S_INIT = 3'b010,
        CIGC_S_USER = 3'b011
    } cigc_fsm_t;

    typedef struct packed {
        logic clr_n;
        logic out_en;
        logic init_done;
        logic startup_clk;
    } cigc_pins_t;

    typedef struct packed {
        logic [`CIGC_SYNC_W-1:0] s1;
        logic [`CIGC_SYNC_W-1:0] s2;
    } cigc_sync_t;

    typedef struct packed {
        cigc_fsm_t fsm;
        logic [3:0] opts;
        logic opt_loaded;
        logic [`CIGC_INIT_CNT_W-1:0] init_cnt;
        logic [`CIGC_DIV_W-1:0] div;
        logic clk_prev;
        logic restart_prev;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic user_mode;
        logic dev_reg_clear;
        logic io_tristate;
        cigc_pins_t pin_out;
        cigc_pins_t pin_oe;
        cigc_pins_t user_in;
        logic aw_full;
        logic w_full;
        logic [`CIGC_ADDR_W-1:0] awaddr;
        logic [`CIGC_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [`CIGC_DATA_W-1:0] rdata;
    } cigc_state_t;

endpackage

// ---- design/cigc_sync.sv ----
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`include "cigc_regs.svh"
module cigc_sync
    import cigc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [`CIGC_SYNC_W-1:0] d,
    output logic [`CIGC_SYNC_W-1:0] q
);

    cigc_sync_t st;
    cigc_sync_t next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.s2;

endmodule

// ---- design/cigc_top.sv ----
// configuration pin controller: start-up pacing, completion indicator, global overrides, axi4-lite registers
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "cigc_regs.svh"
module cigc_top
    import cigc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    // dedicated or user pins
    input wire logic config_restart_n,
    input wire cigc_pins_t pin_in,
    output cigc_pins_t pin_out,
    output cigc_pins_t pin_oe,
    // user side of the pins
    input wire cigc_pins_t user_out,
    input wire cigc_pins_t user_oe,
    output cigc_pins_t user_in,
    // configuration data path
    input wire logic cfg_first_frame,
    input wire logic [3:0] cfg_frame_opts,
    input wire logic cfg_data_done,
    // device-wide controls
    output logic user_mode,
    output logic io_tristate,
    output logic dev_reg_clear,
    output logic irq,
    // axi4-lite slave
    input wire logic [`CIGC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`CIGC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CIGC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`CIGC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [`CIGC_SYNC_W-1:0] sq;
    logic restart_s;
    cigc_pins_t pins_s;

    cigc_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .d({config_restart_n, pin_in}),
        .q(sq)
    );

    assign restart_s = sq[`CIGC_SYNC_W-1];
    assign pins_s = cigc_pins_t'(sq[3:0]);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    cigc_state_t st;
    cigc_state_t next_st;

    logic ext_tick;
    logic int_tick;
    logic tristate_req;
    logic clear_req;
    logic drive_done;
    logic [3:0] ev;
    logic [3:0] w1c;
    logic do_write;

    // pacing ticks for initialization
    assign ext_tick = st.opts[`CIGC_OPT_CLK] && pins_s.startup_clk && !st.clk_prev;
    assign int_tick = !st.opts[`CIGC_OPT_CLK] && (st.div == `CIGC_DIV_LAST);
    assign tristate_req = st.opts[`CIGC_OPT_OE] && !pins_s.out_en;
    assign clear_req = st.opts[`CIGC_OPT_CLR] && !pins_s.clr_n;
    // indicator pulled low only once its option has come in
    assign drive_done = st.opts[`CIGC_OPT_INIT] && st.opt_loaded &&
                        ((st.fsm == CIGC_S_CFG) || (st.fsm == CIGC_S_INIT));
    assign do_write = st.aw_full && st.w_full && !st.bvalid;

    always_comb begin
        next_st = st;
        ev = 4'h0;
        w1c = 4'h0;

        // register writes
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `CIGC_RESP_OKAY;
            case (st.awaddr)
                `CIGC_REG_OPTIONS: begin
                    if (st.wstrb[0]) begin
                        next_st.opts = st.wdata[3:0];
                    end
                end
                `CIGC_REG_STATUS: begin
                end
                `CIGC_REG_IRQ_STAT: begin
                    if (st.wstrb[0]) begin
                        w1c = st.wdata[3:0];
                    end
                end
                `CIGC_REG_IRQ_MASK: begin
                    if (st.wstrb[0]) begin
                        next_st.irq_mask = st.wdata[3:0];
                    end
                end
                default: begin
                    next_st.bresp = `CIGC_RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // register reads
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `CIGC_RESP_OKAY;
            next_st.rdata = '0;
            case (s_axi_araddr)
                `CIGC_REG_OPTIONS: begin
                    next_st.rdata[3:0] = st.opts;
                end
                `CIGC_REG_STATUS: begin
                    next_st.rdata[2:0] = st.fsm;
                    next_st.rdata[3] = st.user_mode;
                    next_st.rdata[4] = st.opt_loaded;
                    next_st.rdata[8:5] = pins_s;
                    next_st.rdata[9] = restart_s;
                end
                `CIGC_REG_IRQ_STAT: begin
                    next_st.rdata[3:0] = st.irq_stat;
                end
                `CIGC_REG_IRQ_MASK: begin
                    next_st.rdata[3:0] = st.irq_mask;
                end
                default: begin
                    next_st.rresp = `CIGC_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // internal pacing divider
        if (st.div == `CIGC_DIV_LAST) begin
            next_st.div = '0;
        end else begin
            next_st.div = st.div + `CIGC_DIV_W'(1);
        end
        next_st.clk_prev = pins_s.startup_clk;
        next_st.restart_prev = restart_s;

        // configuration and initialization sequence
        if (!restart_s) begin
            next_st.fsm = CIGC_S_HOLD;
            next_st.opt_loaded = 1'b0;
            next_st.init_cnt = '0;
        end else begin
            case (st.fsm)
                CIGC_S_HOLD: begin
                    next_st.fsm = CIGC_S_CFG;
                end
                CIGC_S_CFG: begin
                    if (cfg_first_frame) begin
                        next_st.opts = cfg_frame_opts;
                        next_st.opt_loaded = 1'b1;
                    end
                    if (cfg_data_done) begin
                        next_st.fsm = CIGC_S_INIT;
                        next_st.init_cnt = '0;
                    end
                end
                CIGC_S_INIT: begin
                    if (ext_tick || int_tick) begin
                        if (st.init_cnt == `CIGC_INIT_LAST) begin
                            next_st.fsm = CIGC_S_USER;
                        end else begin
                            next_st.init_cnt = st.init_cnt + `CIGC_INIT_CNT_W'(1);
                        end
                    end
                end
                CIGC_S_USER: begin
                end
                default: begin
                    next_st.fsm = CIGC_S_HOLD;
                end
            endcase
        end

        // device-wide overrides
        next_st.io_tristate = tristate_req;
        next_st.dev_reg_clear = clear_req;
        next_st.user_mode = (st.fsm == CIGC_S_USER);

        // pins: dedicated when option on, user i/o otherwise
        for (int i = 0; i < 4; i++) begin
            if (st.opts[i]) begin
                next_st.pin_out[i] = 1'b0;
                next_st.pin_oe[i] = 1'b0;
                next_st.user_in[i] = 1'b0;
            end else begin
                next_st.pin_out[i] = user_out[i];
                next_st.pin_oe[i] = user_oe[i] && !tristate_req;
                next_st.user_in[i] = pins_s[i];
            end
        end
        if (st.opts[`CIGC_OPT_INIT]) begin
            next_st.pin_out.init_done = 1'b0;
            next_st.pin_oe.init_done = drive_done;
        end

        // interrupt events, set wins over clear
        ev[`CIGC_EV_USER] = (st.fsm == CIGC_S_USER) && !st.user_mode;
        ev[`CIGC_EV_RESTART] = st.restart_prev && !restart_s;
        ev[`CIGC_EV_CLEAR] = clear_req && !st.dev_reg_clear;
        ev[`CIGC_EV_TRISTATE] = tristate_req && !st.io_tristate;
        next_st.irq_stat = (st.irq_stat & ~w1c) | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // channel readiness
        next_st.awready = !next_st.aw_full && !next_st.bvalid;
        next_st.wready = !next_st.w_full && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign pin_out = st.pin_out;
    assign pin_oe = st.pin_oe;
    assign user_in = st.user_in;
    assign user_mode = st.user_mode;
    assign io_tristate = st.io_tristate;
    assign dev_reg_clear = st.dev_reg_clear;
    assign irq = st.irq;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_ext_pace;
        (ce && st.opts[`CIGC_OPT_CLK] && st.fsm == CIGC_S_INIT && !ext_tick && restart_s)
            |=> $stable(st.init_cnt) && st.fsm == CIGC_S_INIT;
    endproperty
    a_ext_pace: assert property (p_ext_pace) else $error("init advanced without start-up clock edge");

    property p_restart_release;
        (ce && !restart_s) ##1 (ce && st.opts[`CIGC_OPT_INIT]) |=> !pin_oe.init_done;
    endproperty
    a_restart_release: assert property (p_restart_release) else $error("indicator driven during restart");

    property p_option_drive;
        (ce && restart_s && st.fsm == CIGC_S_CFG && st.opt_loaded && st.opts[`CIGC_OPT_INIT])
            |=> pin_oe.init_done && !pin_out.init_done;
    endproperty
    a_option_drive: assert property (p_option_drive) else $error("indicator not driven low after option load");

    property p_user_release;
        $rose(user_mode) && $past(st.opts[`CIGC_OPT_INIT]) |-> !pin_oe.init_done;
    endproperty
    a_user_release: assert property (p_user_release) else $error("indicator still driven in user mode");

    property p_tristate;
        (ce && tristate_req) |=> io_tristate && !pin_oe.startup_clk;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pins not tristated by global output enable");

    property p_clear;
        (ce && st.opts[`CIGC_OPT_CLR]) |=> dev_reg_clear == !$past(pins_s.clr_n);
    endproperty
    a_clear: assert property (p_clear) else $error("global clear not followed");

    property p_user_io;
        (ce && !st.opts[`CIGC_OPT_INIT] && !tristate_req)
            |=> pin_oe.init_done == $past(user_oe.init_done) && pin_out.init_done == $past(user_out.init_done);
    endproperty
    a_user_io: assert property (p_user_io) else $error("disabled indicator pin not user i/o");

    property p_int_pace;
        (ce && !st.opts[`CIGC_OPT_CLK] && st.fsm == CIGC_S_INIT && st.div != `CIGC_DIV_LAST && restart_s)
            |=> $stable(st.init_cnt) && st.fsm == CIGC_S_INIT;
    endproperty
    a_int_pace: assert property (p_int_pace) else $error("init advanced off internal tick");

    property p_restart_hold;
        (ce && !restart_s) |=> st.fsm == CIGC_S_HOLD && !st.opt_loaded;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart did not return to hold");

    property p_frame_load;
        (ce && restart_s && st.fsm == CIGC_S_CFG && cfg_first_frame)
            |=> st.opt_loaded && st.opts == $past(cfg_frame_opts);
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("option frame not loaded");

    property p_user_entry;
        (ce && restart_s && st.fsm == CIGC_S_INIT && st.init_cnt == `CIGC_INIT_LAST && (ext_tick || int_tick))
            |=> st.fsm == CIGC_S_USER ##1 user_mode;
    endproperty
    a_user_entry: assert property (p_user_entry) else $error("user mode not entered after last tick");

    property p_user_in;
        (ce && !st.opts[`CIGC_OPT_CLR]) |=> user_in.clr_n == $past(pins_s.clr_n);
    endproperty
    a_user_in: assert property (p_user_in) else $error("disabled clear pin not passed to user logic");

endmodule

// ---- tb/cigc_partner.sv ----
// model of the external configuration controller and indicator monitor
`timescale 1ns/1ps
module cigc_partner
    import cigc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic restart_req,
    input wire logic clk_run,
    input wire cigc_pins_t lvl,
    input wire cigc_pins_t pin_out,
    input wire cigc_pins_t pin_oe,
    output logic config_restart_n,
    output cigc_pins_t pin_in,
    output int rise_count
);
    logic sclk = 1'b0;
    logic ph = 1'b0;
    logic line_prev = 1'b1;
    cigc_pins_t src;
    initial rise_count = 0;
    // restart level, driven straight from restart_req
    assign config_restart_n = restart_req;
    // indicator has a pull-up; start-up clock pin rests at lvl.startup_clk when stopped (high while lvl is 4'hF)
    assign src = {lvl.clr_n, lvl.out_en, 1'b1, lvl.startup_clk ^ sclk};
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
    // start-up clock, four cycles a period, finishes its high phase on stop
    always @(posedge sys_clk) begin
        ph <= ~ph;
        if (ph && (clk_run || sclk)) begin
            sclk <= ~sclk;
        end
    end
    // monitor counts low-to-high moves of the indicator line
    always @(posedge sys_clk) begin
        line_prev <= pin_in.init_done;
        if (pin_in.init_done && !line_prev) begin
            rise_count <= rise_count + 1;
        end
    end
endmodule

// ---- tb/config_init_global_control_tb.sv ----
// self-checking bench of the configuration pin controller
`timescale 1ns/1ps
`include "cigc_regs.svh"
module config_init_global_control_tb
    import cigc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic restart_req = 1'b0;
    logic clk_run = 1'b0;
    logic first_frame = 1'b0;
    logic data_done = 1'b0;
    logic [3:0] frame_opts = 4'h0;
    cigc_pins_t lvl = 4'hF;
    cigc_pins_t user_out = 4'h0;
    cigc_pins_t user_oe = 4'h0;
    cigc_pins_t pin_in, pin_out, pin_oe, user_in;
    logic config_restart_n, user_mode, io_tristate, dev_reg_clear, irq;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int rises;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int model [4];
    ////////////////////////////////////////
    cigc_top u_cigc_top (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .config_restart_n(config_restart_n),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .user_out(user_out), .user_oe(user_oe),
        .user_in(user_in), .cfg_first_frame(first_frame), .cfg_frame_opts(frame_opts),
        .cfg_data_done(data_done), .user_mode(user_mode), .io_tristate(io_tristate),
        .dev_reg_clear(dev_reg_clear), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cigc_partner u_cigc_partner (.sys_clk(sys_clk), .restart_req(restart_req), .clk_run(clk_run), .lvl(lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .config_restart_n(config_restart_n), .pin_in(pin_in),
        .rise_count(rises));
    ////////////////////////////////////////
    always #12.5 sys_clk = ~sys_clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > `CIGC_REG_IRQ_MASK) ? `CIGC_RESP_SLVERR : `CIGC_RESP_OKAY;
    endfunction
    // write, release each channel when taken, then wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge sys_clk); while (!bvalid);
        bready <= 1'b0;
        check("write response", bresp, resp_of(a));
        if (a == `CIGC_REG_OPTIONS || a == `CIGC_REG_IRQ_MASK) model[a[3:2]] = d & 32'hF;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        rready <= 1'b0;
        check("read data", rdata & m, e);
        check("read response", rresp, resp_of(a));
    endtask
    ////////////////////////////////////////
    task automatic run_cfg(input logic [3:0] opts);
        int n;
        int r0;
        wr(`CIGC_REG_IRQ_STAT, 32'h1);
        r0 = rises;
        restart_req <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check("indicator oe in restart", pin_oe.init_done, 1'b0);
        rd_chk(`CIGC_REG_STATUS, 32'h7, 32'h0);
        restart_req <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("indicator oe at start", pin_oe.init_done, 1'b0);
        rd_chk(`CIGC_REG_STATUS, 32'h7, 32'h1);
        first_frame <= 1'b1;
        frame_opts <= opts;
        @(posedge sys_clk);
        first_frame <= 1'b0;
        model[0] = opts;
        repeat (3) @(posedge sys_clk);
        check("indicator oe after options", pin_oe.init_done, opts[`CIGC_OPT_INIT]);
        check("indicator line after options", pin_in.init_done, !opts[`CIGC_OPT_INIT]);
        data_done <= 1'b1;
        @(posedge sys_clk);
        data_done <= 1'b0;
        if (opts[`CIGC_OPT_CLK]) begin
            repeat (100) @(posedge sys_clk);
            check("user mode with start-up clock stopped", user_mode, 1'b0);
            clk_run <= 1'b1;
        end
        n = 0;
        while (!user_mode && n < 400) begin
            @(posedge sys_clk);
            n++;
        end
        check("user mode", user_mode, 1'b1);
        check("pacing length", opts[0] ? n <= 48 : (n >= 56 && n <= 80), 1'b1);
        check("indicator released", pin_oe.init_done, 1'b0);
        clk_run <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("indicator rises seen", rises, r0 + opts[`CIGC_OPT_INIT]);
        rd_chk(`CIGC_REG_IRQ_STAT, 32'h1, 32'h1);
        rd_chk(`CIGC_REG_OPTIONS, 32'hF, model[0]);
        $display("test configuration run %h done", opts);
    endtask
    ////////////////////////////////////////
    initial begin
        cigc_pins_t e_in;
        void'($urandom(28715));
        repeat (20) @(posedge sys_clk);
        check("pins in reset", pin_oe, 4'h0);
        nrst <= 1'b1;
        rd_chk(`CIGC_REG_OPTIONS, 32'hF, 32'h0);
        rd_chk(`CIGC_REG_IRQ_MASK, 32'hF, 32'h0);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        wr(8'h14, 32'hF);
        wr(`CIGC_REG_STATUS, 32'hFFFFFFFF);
        $display("test register map done");
        run_cfg(4'h3);
        run_cfg(4'hE);
        user_oe <= 4'h1;
        user_out <= 4'h1;
        wr(`CIGC_REG_IRQ_STAT, 32'hF);
        lvl.out_en <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check("tristate override", io_tristate, 1'b1);
        check("user pin oe under override", pin_oe.startup_clk, 1'b0);
        lvl.out_en <= 1'b1;
        lvl.clr_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check("tristate released", io_tristate, 1'b0);
        check("user pin oe released", pin_oe.startup_clk, 1'b1);
        check("global clear", dev_reg_clear, 1'b1);
        lvl.clr_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check("global clear released", dev_reg_clear, 1'b0);
        rd_chk(`CIGC_REG_IRQ_STAT, 32'hF, 32'hC);
        wr(`CIGC_REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge sys_clk);
        check("irq unmasked", irq, 1'b1);
        wr(`CIGC_REG_IRQ_MASK, 32'h3);
        repeat (2) @(posedge sys_clk);
        check("irq masked", irq, 1'b0);
        wr(`CIGC_REG_IRQ_STAT, 32'h4);
        rd_chk(`CIGC_REG_IRQ_STAT, 32'hF, 32'h8);
        rd_chk(`CIGC_REG_IRQ_MASK, 32'hF, model[3]);
        $display("test overrides and interrupts done");
        wr(`CIGC_REG_OPTIONS, 32'h0);
        rd_chk(`CIGC_REG_OPTIONS, 32'hF, model[0]);
        repeat (6) begin
            lvl <= 4'($urandom) & 4'h3;
            user_oe <= 4'($urandom);
            user_out <= 4'($urandom);
            repeat (6) @(posedge sys_clk);
            e_in = (user_oe & user_out) | (~user_oe & (lvl | 4'h2));
            check("pin oe as user", pin_oe, user_oe);
            check("pin out as user", pin_out, user_out);
            check("user pin input", user_in, e_in);
            check("no override when off", {io_tristate, dev_reg_clear}, 2'h0);
        end
        $display("test user pins done");
        report_and_stop();
    end
endmodule
